// File: shared/pftw_pkg.sv
// constants and types for the primary flow-through wait control
`default_nettype none

package pftw_pkg;

	// register map, byte addresses on the apb bus
	localparam logic [11:0] PFTW_CTL_OFFSET  = 12'h044;
	localparam logic [11:0] PFTW_STAT_OFFSET = 12'h048;

	// control register layout and reset value
	localparam logic [7:0]  PFTW_CTL_RESET = 8'h00;
	localparam logic [7:0]  PFTW_CTL_WMASK = 8'h77;
	localparam int          PFTW_WR_LSB    = 0;
	localparam int          PFTW_RD_LSB    = 4;
	localparam int          PFTW_CODE_W    = 3;

	// status register layout
	localparam int          PFTW_ST_WR_HOLD = 0;
	localparam int          PFTW_ST_RD_HOLD = 1;
	localparam int          PFTW_ST_WR_CNT  = 4;
	localparam int          PFTW_ST_RD_CNT  = 8;

	// wait code meanings and counter constants
	localparam logic [2:0]  PFTW_CODE_NOW  = 3'h0;
	localparam logic [2:0]  PFTW_CODE_ONE  = 3'h1;
	localparam logic [2:0]  PFTW_CODE_MAX  = 3'h7;
	localparam logic [2:0]  PFTW_CNT_LAST  = 3'h1;
	localparam logic [2:0]  PFTW_CNT_RESET = 3'h0;
	localparam logic [31:0] PFTW_RDATA_RESET = 32'h0000_0000;

	// wait sequencer states, gray along idle, wait, terminate
	typedef enum logic [1:0] {
		PFTW_IDLE = 2'b00,
		PFTW_WAIT = 2'b01,
		PFTW_TERM = 2'b11
	} pftw_state_t;

endpackage

`default_nettype wire

// File: shared/pftw_wait_if.sv
// carrier between the register block and one wait sequencer
`default_nettype none

interface pftw_wait_if;
	logic       flow;
	logic       near;
	logic       fresh;
	logic [2:0] code;
	logic       hold;
	logic       term;
	logic [2:0] cnt;

	modport ctl (output flow, output near, output fresh, output code,
		input hold, input term, input cnt);
	modport wt  (input flow, input near, input fresh, input code,
		output hold, output term, output cnt);
endinterface

`default_nettype wire

// File: core/pftw_wait.sv
// one flow-through wait sequencer: hold ready, count, then terminate
`default_nettype none

module pftw_wait
	import pftw_pkg::*;
(
	input  wire logic  pclk,
	input  wire logic  presetn,
	pftw_wait_if.wt    wif
);

	typedef struct packed {
		pftw_state_t state;
		logic [2:0]  cnt;
	} pftw_wait_st_t;

	pftw_wait_st_t st_reg;
	pftw_wait_st_t st_next;

	// next state: wait up to code clocks for fresh data or space
	always_comb begin
		st_next = st_reg;
		case (st_reg.state)
			PFTW_IDLE: begin
				if (wif.flow && wif.near) begin
					if (wif.code == PFTW_CODE_NOW) begin
						st_next.state = PFTW_TERM; // code 000 ends at once
					end else begin
						st_next.state = PFTW_WAIT; // ready dropped
						st_next.cnt   = wif.code; // wait code clocks
					end
				end
			end
			PFTW_WAIT: begin
				if (!wif.flow || wif.fresh) begin
					st_next.state = PFTW_IDLE; // data or space came, resume
					st_next.cnt   = PFTW_CNT_RESET;
				end else if (st_reg.cnt == PFTW_CNT_LAST) begin
					st_next.state = PFTW_TERM; // count spent
					st_next.cnt   = PFTW_CNT_RESET;
				end else begin
					st_next.cnt = st_reg.cnt - PFTW_CNT_LAST;
				end
			end
			PFTW_TERM: begin
				st_next.state = PFTW_IDLE; // one-cycle terminate pulse
			end
			default: begin
				st_next.state = PFTW_IDLE;
				st_next.cnt   = PFTW_CNT_RESET;
			end
		endcase
	end

	// state register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_reg.state <= PFTW_IDLE;
			st_reg.cnt   <= PFTW_CNT_RESET;
		end else begin
			st_reg <= st_next;
		end
	end

	// outputs decoded from registered state
	assign wif.hold = (st_reg.state == PFTW_WAIT);
	assign wif.term = (st_reg.state == PFTW_TERM);
	assign wif.cnt  = st_reg.cnt;

endmodule // pftw_wait

`default_nettype wire

// File: core/pftw_top.sv
// apb register block and both flow-through wait sequencers
//
// Implementation choice: register access over APB.
`default_nettype none

// Operation
// - write wait spent without data ends target write cycle, rest later.
// - write code 000 ends target write when one queue entry remains.
// - write code 001 drops irdy, waits one clock, then ends cycle.
// - control bits 3 and 7 always read back zero.
// - read wait spent without space ends target read; initiator retries.
// - read code 000 ends target read when one queue entry remains.
// - read code 001 drops trdy, waits one clock, then ends cycle.
// - read code 111 waits up to seven clocks before ending.
module pftw_top
	import pftw_pkg::*;
(
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	input  wire logic [3:0]  pstrb,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        wr_flow,
	input  wire logic        wr_queue_last,
	input  wire logic        wr_src_data,
	output logic             wr_irdy_hold,
	output logic             wr_term,
	input  wire logic        rd_flow,
	input  wire logic        rd_queue_last,
	input  wire logic        rd_space_free,
	output logic             rd_trdy_hold,
	output logic             rd_term
);

	typedef struct packed {
		logic [7:0]  ctl;
		logic [31:0] rdata;
		logic        slverr;
	} pftw_top_st_t;

	pftw_top_st_t st_reg;
	pftw_top_st_t st_next;

	pftw_wait_if wr_if ();
	pftw_wait_if rd_if ();

	logic        setup;
	logic        wr_access;
	logic        sel_ctl;
	logic        sel_stat;
	logic [31:0] stat_word;

	// apb phase and address decode
	assign setup     = psel && !penable;
	assign wr_access = psel && penable && pwrite;
	assign sel_ctl   = (paddr == PFTW_CTL_OFFSET);
	assign sel_stat  = (paddr == PFTW_STAT_OFFSET);

	// status word built from both sequencers
	always_comb begin
		stat_word = 32'h0000_0000;
		stat_word[PFTW_ST_WR_HOLD] = wr_if.hold;
		stat_word[PFTW_ST_RD_HOLD] = rd_if.hold;
		stat_word[PFTW_ST_WR_CNT +: PFTW_CODE_W] = wr_if.cnt;
		stat_word[PFTW_ST_RD_CNT +: PFTW_CODE_W] = rd_if.cnt;
	end

	// register writes in access phase, read data and error captured at setup
	always_comb begin
		st_next = st_reg;
		if (wr_access && sel_ctl && pstrb[0]) begin
			st_next.ctl = pwdata[7:0] & PFTW_CTL_WMASK;
		end
		if (setup) begin
			st_next.slverr = !(sel_ctl || sel_stat);
			st_next.rdata  = PFTW_RDATA_RESET;
			if (sel_ctl) begin
				st_next.rdata[7:0] = st_reg.ctl & PFTW_CTL_WMASK;
			end else if (sel_stat) begin
				st_next.rdata = stat_word;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_reg.ctl    <= PFTW_CTL_RESET;
			st_reg.rdata  <= PFTW_RDATA_RESET;
			st_reg.slverr <= 1'b0;
		end else begin
			st_reg <= st_next;
		end
	end

	// apb answers: zero wait access phase
	assign pready  = 1'b1;
	assign prdata  = st_reg.rdata;
	assign pslverr = st_reg.slverr && psel && penable;

	// posted write path: wait for initiator data while queue nearly empty
	assign wr_if.flow  = wr_flow;
	assign wr_if.near  = wr_queue_last;
	assign wr_if.fresh = wr_src_data;
	assign wr_if.code  = st_reg.ctl[PFTW_WR_LSB +: PFTW_CODE_W];

	// delayed read path: wait for queue space while queue nearly full
	assign rd_if.flow  = rd_flow;
	assign rd_if.near  = rd_queue_last;
	assign rd_if.fresh = rd_space_free;
	assign rd_if.code  = st_reg.ctl[PFTW_RD_LSB +: PFTW_CODE_W];

	// two sequencers, hold and terminate per path
	pftw_wait u_wr_wait (
		.pclk    (pclk),
		.presetn (presetn),
		.wif     (wr_if.wt)
	);

	pftw_wait u_rd_wait (
		.pclk    (pclk),
		.presetn (presetn),
		.wif     (rd_if.wt)
	);

	assign wr_irdy_hold = wr_if.hold;
	assign wr_term      = wr_if.term;
	assign rd_trdy_hold = rd_if.hold;
	assign rd_term      = rd_if.term;

	// checks on the reserved control bits and the wait behaviour
	logic wr_idle;
	logic rd_idle;
	assign wr_idle = !wr_if.hold && !wr_if.term;
	assign rd_idle = !rd_if.hold && !rd_if.term;

	AST_CTL_RSVD_ZERO: assert property (
		@(posedge pclk) disable iff (!presetn)
		(setup && sel_ctl) |=> (prdata[3] == 1'b0 && prdata[7] == 1'b0))
		else $error("reserved control bit read back as one");

	AST_WR_BOUND: assert property (
		@(posedge pclk) disable iff (!presetn)
		wr_if.hold |-> (wr_if.cnt != 3'h0))
		else $error("write wait counter empty while holding");

	AST_WR_EXPIRE: assert property (
		@(posedge pclk) disable iff (!presetn)
		(wr_if.hold && wr_flow && !wr_src_data && wr_if.cnt == PFTW_CNT_LAST)
		|=> wr_term)
		else $error("write wait spent but no terminate");

	AST_WR_CODE0: assert property (
		@(posedge pclk) disable iff (!presetn)
		(wr_idle && wr_flow && wr_queue_last && wr_if.code == PFTW_CODE_NOW)
		|=> (wr_term && !wr_irdy_hold))
		else $error("write code zero did not terminate at once");

	AST_WR_CODE1: assert property (
		@(posedge pclk) disable iff (!presetn)
		(wr_idle && wr_flow && wr_queue_last && wr_if.code == PFTW_CODE_ONE)
		##1 (wr_flow && !wr_src_data) |-> wr_irdy_hold ##1 wr_term)
		else $error("write code one did not hold one clock then end");

	AST_RD_BOUND: assert property (
		@(posedge pclk) disable iff (!presetn)
		rd_if.hold |-> (rd_if.cnt != 3'h0))
		else $error("read wait counter empty while holding");

	AST_RD_EXPIRE: assert property (
		@(posedge pclk) disable iff (!presetn)
		(rd_if.hold && rd_flow && !rd_space_free && rd_if.cnt == PFTW_CNT_LAST)
		|=> rd_term)
		else $error("read wait spent but no terminate");

	AST_RD_CODE0: assert property (
		@(posedge pclk) disable iff (!presetn)
		(rd_idle && rd_flow && rd_queue_last && rd_if.code == PFTW_CODE_NOW)
		|=> (rd_term && !rd_trdy_hold))
		else $error("read code zero did not terminate at once");

	AST_RD_CODE1: assert property (
		@(posedge pclk) disable iff (!presetn)
		(rd_idle && rd_flow && rd_queue_last && rd_if.code == PFTW_CODE_ONE)
		##1 (rd_flow && !rd_space_free) |-> rd_trdy_hold ##1 rd_term)
		else $error("read code one did not hold one clock then end");

	AST_RD_SEVEN: assert property (
		@(posedge pclk) disable iff (!presetn)
		(rd_idle && rd_flow && rd_queue_last && rd_if.code == PFTW_CODE_MAX)
		##1 (rd_flow && !rd_space_free)[*7]
		|-> (rd_trdy_hold && $past(rd_trdy_hold, 6) && rd_if.cnt == PFTW_CNT_LAST) ##1 rd_term)
		else $error("read code seven did not wait seven clocks");

	AST_WR_STEP: assert property (
		@(posedge pclk) disable iff (!presetn)
		(wr_if.hold && wr_flow && !wr_src_data && wr_if.cnt > PFTW_CNT_LAST)
		|=> (wr_irdy_hold && wr_if.cnt == $past(wr_if.cnt) - 3'h1 && !wr_term))
		else $error("write wait did not count down with irdy held");

	// read path steps down one count per held clock
	AST_RD_STEP: assert property (
		@(posedge pclk) disable iff (!presetn)
		(rd_if.hold && rd_flow && !rd_space_free && rd_if.cnt > PFTW_CNT_LAST)
		|=> (rd_trdy_hold && rd_if.cnt == $past(rd_if.cnt) - 3'h1 && !rd_term))
		else $error("read wait did not count down with trdy held");

	// scenarios worth seeing reached
	COV_WR_EXPIRE: cover property (@(posedge pclk) disable iff (!presetn)
		wr_irdy_hold ##1 wr_term);
	COV_WR_NOW: cover property (@(posedge pclk) disable iff (!presetn)
		wr_idle && wr_flow && wr_queue_last && wr_if.code == PFTW_CODE_NOW ##1 wr_term);
	COV_STAT_READ: cover property (@(posedge pclk) disable iff (!presetn)
		setup && sel_stat && rd_trdy_hold);
	COV_RD_RESUME: cover property (@(posedge pclk) disable iff (!presetn)
		rd_trdy_hold && rd_space_free ##1 rd_idle);
	COV_APB_ERR: cover property (@(posedge pclk) disable iff (!presetn)
		pslverr);

endmodule // pftw_top

`default_nettype wire

// File: bench/pftw_far.sv
// far-side model of one queue path: opens a flow-through wait, may bring fresh data
`default_nettype none

module pftw_far (
	input  wire logic       pclk,
	input  wire logic       presetn,
	input  wire logic       go,
	input  wire logic [3:0] fresh_at,
	input  wire logic       hold,
	input  wire logic       term,
	output logic            flow,
	output logic            last,
	output logic            fresh
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [3:0] hc;

	// queue nears its limit on go, backs off on term or once fresh data lands
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			{flow, last, fresh, hc} <= '0;
		end else begin
			fresh <= 1'b0;
			if (go) begin
				{flow, last, hc} <= {2'b11, 4'h0};
			end else if (term) begin
				{flow, last} <= 2'b00; // cycle cut, rest fetched on retry
			end else if (hold && flow) begin
				hc <= hc + 4'h1;
				if (hc + 4'h1 == fresh_at) begin
					{flow, last, fresh} <= 3'b001; // fresh data or space arrives
				end
			end
		end
	end
endmodule // pftw_far

`default_nettype wire

// File: bench/pftw_top_tb.sv
// self-checking bench for the flow-through wait control block
`default_nettype none

module pftw_top_tb;
	import pftw_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, wh, rh, wt, rt, q;
	logic [3:0]  pstrb, wfa, rfa;
	logic        wr_flow, wr_queue_last, wr_src_data, wr_irdy_hold, wr_term;
	logic        rd_flow, rd_queue_last, rd_space_free, rd_trdy_hold, rd_term;
	logic        go, clr, e;
	int          miscompares, n_compared;

	pftw_top dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
		.prdata, .pready, .pslverr, .wr_flow, .wr_queue_last, .wr_src_data, .wr_irdy_hold,
		.wr_term, .rd_flow, .rd_queue_last, .rd_space_free, .rd_trdy_hold, .rd_term);
	pftw_far u_wr (.pclk, .presetn, .go, .fresh_at(wfa), .hold(wr_irdy_hold),
		.term(wr_term), .flow(wr_flow), .last(wr_queue_last), .fresh(wr_src_data));
	pftw_far u_rd (.pclk, .presetn, .go, .fresh_at(rfa), .hold(rd_trdy_hold),
		.term(rd_term), .flow(rd_flow), .last(rd_queue_last), .fresh(rd_space_free));

	// clock
	initial begin
		pclk = 1'b0;
		forever #2.5 pclk = ~pclk;
	end

	// cycles spent holding and terminating on each path
	always @(posedge pclk) begin
		wh <= clr ? 32'h0 : wh + wr_irdy_hold;
		rh <= clr ? 32'h0 : rh + rd_trdy_hold;
		wt <= clr ? 32'h0 : wt + wr_term;
		rt <= clr ? 32'h0 : rt + rd_term;
	end

	task automatic chk(input string what, input logic [31:0] x, input logic [31:0] g);
		n_compared++;
		if (g !== x) begin
			miscompares++;
			$display("Error %s expected %h seen %h", what, x, g);
		end
	endtask

	// one apb transfer; held until pready is sampled high
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) begin
			@(posedge pclk);
		end
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	// program both codes, open both waits, count hold and term cycles
	task automatic run(input logic [2:0] wc, input logic [2:0] rc, input logic [3:0] fa,
			input logic [31:0] ew, input logic [31:0] er, input logic [31:0] et);
		apb(1'b1, PFTW_CTL_OFFSET, {25'h0, rc, 1'b0, wc});
		@(posedge pclk);
		{go, clr, wfa, rfa} <= {2'b11, fa, fa};
		@(posedge pclk);
		{go, clr} <= 2'b00;
		repeat (14) @(posedge pclk);
		chk("write hold cycles", ew, wh);
		chk("read hold cycles", er, rh);
		chk("write term pulses", et, wt);
		chk("read term pulses", et, rt);
	endtask

	task automatic test_reset();
		apb(1'b0, PFTW_CTL_OFFSET, 32'h0);
		chk("control after reset", {24'h0, PFTW_CTL_RESET}, q);
		chk("control error", 32'h0, {31'h0, e});
		chk("ready in access", 32'h1, {31'h0, pready});
		apb(1'b0, PFTW_STAT_OFFSET, 32'h0);
		chk("status after reset", 32'h0, q);
		chk("status error", 32'h0, {31'h0, e});
	endtask

	task automatic test_reserved();
		apb(1'b1, PFTW_CTL_OFFSET, 32'hffff_ffff);
		apb(1'b0, PFTW_CTL_OFFSET, 32'h0);
		chk("control all ones", 32'h0000_0077, q);
		pstrb <= 4'h0;
		apb(1'b1, PFTW_CTL_OFFSET, 32'h0);
		pstrb <= 4'hf;
		apb(1'b1, PFTW_STAT_OFFSET, 32'h0);
		apb(1'b0, PFTW_CTL_OFFSET, 32'h0);
		chk("control after masked writes", 32'h0000_0077, q);
	endtask

	task automatic test_unmapped();
		apb(1'b0, 12'h100, 32'h0);
		chk("unmapped data", 32'h0, q);
		chk("unmapped error", 32'h1, {31'h0, e});
	endtask

	// every code on both paths, read field opposite to write field
	task automatic test_codes();
		for (int i = 0; i < 8; i++) begin
			run(3'(i), 3'(7 - i), 4'h0, 32'(i), 32'(7 - i), 32'h1);
		end
	endtask

	// fresh data in the third hold cycle resumes without termination
	task automatic test_fresh();
		run(3'h5, 3'h5, 4'h2, 32'h3, 32'h3, 32'h0);
	endtask

	// status read in the first hold clock of code 111 on both paths
	task automatic test_status();
		apb(1'b1, PFTW_CTL_OFFSET, 32'h0000_0077);
		@(posedge pclk);
		{go, wfa, rfa} <= {1'b1, 4'h0, 4'h0};
		@(posedge pclk);
		go <= 1'b0;
		apb(1'b0, PFTW_STAT_OFFSET, 32'h0);
		chk("status while holding", 32'h0000_0773, q);
		chk("status hold error", 32'h0, {31'h0, e});
		repeat (12) @(posedge pclk);
	endtask

	task automatic report_and_stop();
		$display("compared %0d mismatched %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	// main sequence
	initial begin
		{presetn, psel, penable, pwrite, go, clr} = '0;
		{paddr, pwdata, wfa, rfa} = '0;
		pstrb = 4'hf;
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		test_reset();
		test_reserved();
		test_unmapped();
		test_codes();
		test_fresh();
		test_status();
		report_and_stop();
	end

	// watchdog against a hung handshake
	initial begin
		#20000;
		miscompares++;
		report_and_stop();
	end
endmodule // pftw_top_tb

`default_nettype wire
